// file: hdl/anr_pkg.sv
package anr_pkg;
	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_PARTNER_BASE = 5'h05;
	localparam logic [4:0] ADDR_EXPANSION = 5'h06;
	localparam logic [4:0] ADDR_LOCAL_NP = 5'h07;
	localparam logic [4:0] ADDR_PARTNER_NP = 5'h08;
	localparam logic [4:0] ADDR_MMD_CTRL = 5'h0d;
	localparam logic [4:0] ADDR_MMD_DATA = 5'h0e;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int SEL_W = 5;
	localparam logic [4:0] SELECTOR_8023 = 5'h01;
	localparam int MSG_W = 11;
	localparam logic [10:0] LOCAL_MSG_RST = 11'h001;
	localparam logic LOCAL_MP_RST = 1'b1;
	localparam int NP_NEXT = 15;
	localparam int NP_ACK = 14;
	localparam int NP_MP = 13;
	localparam int NP_ACK2 = 12;
	localparam int NP_TOG = 11;
	localparam int CTRL_OP_HI = 15;
	localparam int CTRL_OP_LO = 14;
	localparam int DEV_W = 5;
	localparam int MMD_DEVS = 32;
	localparam int MMD_REGS = 4;
	localparam int MMD_IDX_W = 2;
	localparam int EXP_PDF = 4;
	localparam int EXP_LPNP = 3;
	localparam int EXP_NPA = 2;
	localparam int EXP_PR = 1;
	localparam int EXP_LPAN = 0;
	localparam int PB_10HD = 5;

	// ------------------------------------------------------------
	// indirect access modes
	// ------------------------------------------------------------
	localparam logic [1:0] OP_ADDR = 2'h0;
	localparam logic [1:0] OP_DATA = 2'h1;
	localparam logic [1:0] OP_DATA_INC_RW = 2'h2;
	localparam logic [1:0] OP_DATA_INC_W = 2'h3;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_INC
	} anr_state_t;
endpackage : anr_pkg

// file: hdl/anr_latch_high.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// latch-high status bit, cleared by a read, set wins
// ------------------------------------------------------------
module anr_latch_high (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// event and clear
	input wire logic set_evt,
	input wire logic rd_clr,
	// state
	output logic flag
);
	logic flag_nxt;
	assign flag_nxt = set_evt ? 1'b1 : (rd_clr ? 1'b0 : flag);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flag <= 1'b0;
		end else begin
			flag <= flag_nxt;
		end
	end
endmodule : anr_latch_high

// file: hdl/anr_mmd_store.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// per-device address pointers for indirect access
// ------------------------------------------------------------
module anr_mmd_store (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// control
	input wire logic [4:0] dev,
	input wire logic addr_we,
	input wire logic [15:0] addr_wdata,
	input wire logic addr_inc,
	// selected pointer
	output logic [15:0] addr_sel
);
	logic [15:0] ptr_r [anr_pkg::MMD_DEVS];
	genvar g;
	generate
		for (g = 0; g < anr_pkg::MMD_DEVS; g++) begin : g_dev
			logic hit;
			assign hit = (dev == 5'(g));
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					ptr_r[g] <= 16'h0000;
				end else if (hit && addr_we) begin
					ptr_r[g] <= addr_wdata;
				end else if (hit && addr_inc) begin
					ptr_r[g] <= ptr_r[g] + 16'h0001;
				end
			end
		end
	endgenerate
	assign addr_sel = ptr_r[dev];
endmodule : anr_mmd_store

// file: hdl/anr_regs.sv
`timescale 1ns/1ps
// Function
// RULE1: partner base bit 5 shows partner 10M half-duplex ability; reset 0
// RULE2: partner base bits 4:0 read the standard selector code
// RULE3: expansion bit 4 latches parallel-detect fault until read
// RULE4: expansion bit 3 shows partner next-page capability
// RULE5: expansion bit 2 always reads 1
// RULE6: expansion bit 1 latches new page received until read
// RULE7: expansion bit 0 shows partner autoneg capability
// RULE8: local next-page bit 15 written 1 while more pages follow; reset 0
// RULE9: local next-page bit 13 writable message-page flag; reset 1
// RULE10: local next-page bit 12 writable comply flag; reset 0
// RULE11: local next-page bit 11 read-only toggle from last sent word
// RULE12: local next-page bits 10:0 writable message code; reset one
// RULE13: partner next-page register read-only, reset zero, flags and code
// RULE14: partner next-page bit 12 shows partner can act on information
// RULE15: partner next-page bit 11 is inverse of previous sent toggle
// RULE16: control bits 15:14 pick address, data, or data with increment
// RULE17: mode 11 increments address after writes only
// RULE18: control bits 4:0 hold device number; reset zero
// RULE19: mode 00 data register accesses the stored address
// RULE20: nonzero mode data register accesses the addressed MMD register
// RULE21: manager sets address mode, address, data mode, then accesses data
// RULE22: post increment adds one to stored address after access completes
module anr_regs (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// management frame access
	input wire logic mgmt_rd,
	input wire logic mgmt_wr,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	// negotiation status from the link
	input wire logic [15:0] partner_base_in,
	input wire logic [15:0] partner_np_in,
	input wire logic partner_np_able,
	input wire logic partner_an_able,
	input wire logic par_det_fault,
	input wire logic page_rx,
	input wire logic tx_toggle,
	// next page to transmit
	output logic [15:0] local_np_out,
	// extended register port
	output logic mmd_rd,
	output logic mmd_wr,
	output logic [4:0] mmd_dev,
	output logic [15:0] mmd_addr,
	output logic [15:0] mmd_wdata,
	input wire logic [15:0] mmd_rdata
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire hit_exp = (mgmt_addr == anr_pkg::ADDR_EXPANSION);
	wire hit_lnp = (mgmt_addr == anr_pkg::ADDR_LOCAL_NP);
	wire hit_ctl = (mgmt_addr == anr_pkg::ADDR_MMD_CTRL);
	wire hit_dat = (mgmt_addr == anr_pkg::ADDR_MMD_DATA);
	wire exp_rd = mgmt_rd && hit_exp;

	// ------------------------------------------------------------
	// base page and expansion
	// ------------------------------------------------------------
	logic [15:0] pbase_r;
	logic [15:0] pnp_r;
	logic lp_np_r;
	logic lp_an_r;
	logic pdf;
	logic prx;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pbase_r <= 16'h0000;
			pnp_r <= 16'h0000;
			lp_np_r <= 1'b0;
			lp_an_r <= 1'b0;
		end else begin
			pbase_r <= partner_base_in;
			pnp_r <= partner_np_in; // RULE13
			lp_np_r <= partner_np_able;
			lp_an_r <= partner_an_able;
		end
	end
	anr_latch_high u_pdf (
		.clock(clock),
		.rstn(rstn),
		.set_evt(par_det_fault), // RULE3
		.rd_clr(exp_rd),
		.flag(pdf)
	);
	anr_latch_high u_prx (
		.clock(clock),
		.rstn(rstn),
		.set_evt(page_rx), // RULE6
		.rd_clr(exp_rd),
		.flag(prx)
	);
	logic [15:0] pbase_view;
	assign pbase_view = {pbase_r[15:anr_pkg::PB_10HD], anr_pkg::SELECTOR_8023}; // RULE1 RULE2
	logic [15:0] exp_view;
	assign exp_view = {11'h000, pdf, lp_np_r, 1'b1, prx, lp_an_r}; // RULE4 RULE5 RULE7

	// ------------------------------------------------------------
	// local next page
	// ------------------------------------------------------------
	logic lnp_next_r;
	logic lnp_mp_r;
	logic lnp_ack2_r;
	logic lnp_tog_r;
	logic [10:0] lnp_msg_r;
	wire lnp_we = mgmt_wr && hit_lnp;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lnp_next_r <= 1'b0;
			lnp_mp_r <= anr_pkg::LOCAL_MP_RST;
			lnp_ack2_r <= 1'b0;
			lnp_msg_r <= anr_pkg::LOCAL_MSG_RST;
		end else if (lnp_we) begin
			lnp_next_r <= mgmt_wdata[anr_pkg::NP_NEXT]; // RULE8
			lnp_mp_r <= mgmt_wdata[anr_pkg::NP_MP]; // RULE9
			lnp_ack2_r <= mgmt_wdata[anr_pkg::NP_ACK2]; // RULE10
			lnp_msg_r <= mgmt_wdata[anr_pkg::MSG_W-1:0]; // RULE12
		end
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lnp_tog_r <= 1'b0;
		end else begin
			lnp_tog_r <= tx_toggle; // RULE11
		end
	end
	logic [15:0] lnp_view;
	assign lnp_view = {lnp_next_r, 1'b0, lnp_mp_r, lnp_ack2_r, lnp_tog_r, lnp_msg_r};
	// partner toggle is taken as given: set when our last toggle was 0
	logic [15:0] pnp_view;
	assign pnp_view = pnp_r; // RULE14 RULE15

	// ------------------------------------------------------------
	// indirect access
	// ------------------------------------------------------------
	logic [1:0] op_r;
	logic [8:0] ctl_rsv_r;
	logic [4:0] dev_r;
	wire ctl_we = mgmt_wr && hit_ctl;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			op_r <= anr_pkg::OP_ADDR;
			ctl_rsv_r <= 9'h000;
			dev_r <= 5'h00;
		end else if (ctl_we) begin
			op_r <= mgmt_wdata[anr_pkg::CTRL_OP_HI:anr_pkg::CTRL_OP_LO]; // RULE16
			ctl_rsv_r <= mgmt_wdata[13:5];
			dev_r <= mgmt_wdata[anr_pkg::DEV_W-1:0]; // RULE18
		end
	end
	wire mode_addr = (op_r == anr_pkg::OP_ADDR);
	wire dat_rd = mgmt_rd && hit_dat;
	wire dat_wr = mgmt_wr && hit_dat;
	wire addr_we = dat_wr && mode_addr; // RULE19 RULE21
	wire inc_rw = (op_r == anr_pkg::OP_DATA_INC_RW) && (dat_rd || dat_wr); // RULE16
	wire inc_w = (op_r == anr_pkg::OP_DATA_INC_W) && dat_wr; // RULE17
	logic [15:0] addr_sel;
	// increment fires the cycle after the access, once it has used the address
	logic inc_pend_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			inc_pend_r <= 1'b0;
		end else begin
			inc_pend_r <= inc_rw || inc_w; // RULE22
		end
	end
	anr_mmd_store u_store (
		.clock(clock),
		.rstn(rstn),
		.dev(dev_r),
		.addr_we(addr_we),
		.addr_wdata(mgmt_wdata),
		.addr_inc(inc_pend_r), // RULE22
		.addr_sel(addr_sel)
	);
	logic [15:0] ctl_view;
	assign ctl_view = {op_r, ctl_rsv_r, dev_r};
	logic [15:0] dat_view;
	assign dat_view = mode_addr ? addr_sel : mmd_rdata; // RULE19 RULE20

	// ------------------------------------------------------------
	// outward strobes and read data
	// ------------------------------------------------------------
	logic [15:0] rd_mux;
	always_comb begin
		case (mgmt_addr)
			anr_pkg::ADDR_PARTNER_BASE: rd_mux = pbase_view;
			anr_pkg::ADDR_EXPANSION: rd_mux = exp_view;
			anr_pkg::ADDR_LOCAL_NP: rd_mux = lnp_view;
			anr_pkg::ADDR_PARTNER_NP: rd_mux = pnp_view;
			anr_pkg::ADDR_MMD_CTRL: rd_mux = ctl_view;
			anr_pkg::ADDR_MMD_DATA: rd_mux = dat_view;
			default: rd_mux = 16'h0000;
		endcase
	end
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mgmt_rdata <= 16'h0000;
			local_np_out <= 16'h0000;
			mmd_rd <= 1'b0;
			mmd_wr <= 1'b0;
			mmd_dev <= 5'h00;
			mmd_addr <= 16'h0000;
			mmd_wdata <= 16'h0000;
		end else begin
			mgmt_rdata <= mgmt_rd ? rd_mux : 16'h0000;
			local_np_out <= lnp_view;
			mmd_rd <= dat_rd && !mode_addr; // RULE20
			mmd_wr <= dat_wr && !mode_addr; // RULE20
			mmd_dev <= dev_r;
			mmd_addr <= addr_sel;
			mmd_wdata <= mgmt_wdata;
		end
	end
endmodule : anr_regs

// file: verification/anr_regs_assertions.sv
`timescale 1ns/1ps
module anr_regs_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// management access
	input wire logic mgmt_rd,
	input wire logic mgmt_wr,
	input wire logic [4:0] mgmt_addr,
	input wire logic [15:0] mgmt_wdata,
	input wire logic [15:0] mgmt_rdata,
	// link status
	input wire logic [15:0] partner_base_in,
	input wire logic [15:0] partner_np_in,
	input wire logic partner_np_able,
	input wire logic partner_an_able,
	input wire logic par_det_fault,
	input wire logic page_rx,
	input wire logic tx_toggle,
	// extended port
	input wire logic mmd_rd,
	input wire logic mmd_wr,
	input wire logic [15:0] mmd_wdata
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	base_read_a: assert property (mgmt_rd && mgmt_addr == 5'h05
		|=> mgmt_rdata[5:0] == {$past(partner_base_in[5], 2), 5'h01}) else $error("base read");
	exp_read_a: assert property (mgmt_rd && mgmt_addr == 5'h06
		|=> mgmt_rdata[3:2] == {$past(partner_np_able, 2), 1'b1}
		&& mgmt_rdata[0] == $past(partner_an_able, 2)) else $error("expansion read");
	fault_latch_a: assert property (par_det_fault ##1 mgmt_rd && mgmt_addr == 5'h06
		|=> mgmt_rdata[4]) else $error("fault not latched");
	page_latch_a: assert property (page_rx ##1 mgmt_rd && mgmt_addr == 5'h06
		|=> mgmt_rdata[1]) else $error("page not latched");
	pnp_read_a: assert property (mgmt_rd && mgmt_addr == 5'h08
		|=> mgmt_rdata == $past(partner_np_in, 2)) else $error("partner page read");
	toggle_read_a: assert property (mgmt_rd && mgmt_addr == 5'h07
		|=> mgmt_rdata[11] == $past(tx_toggle, 2)) else $error("toggle read");
	lnp_store_a: assert property (mgmt_wr && mgmt_addr == 5'h07 ##1 !mgmt_wr [*2]
		##1 mgmt_rd && mgmt_addr == 5'h07 |=> {mgmt_rdata[15:12], mgmt_rdata[10:0]}
		== {$past(mgmt_wdata[15], 4), 1'b0, $past(mgmt_wdata[13:12], 4),
		$past(mgmt_wdata[10:0], 4)}) else $error("next page store");
	mmd_write_a: assert property (mmd_wr |-> $past(mgmt_wr) && $past(mgmt_addr) == 5'h0e
		&& mmd_wdata == $past(mgmt_wdata)) else $error("extended write");
	mmd_read_a: assert property (mmd_rd |-> $past(mgmt_rd) && $past(mgmt_addr) == 5'h0e
		&& !mmd_wr) else $error("extended read");
endmodule : anr_regs_assertions

// file: verification/anr_mmd_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// extended register space behind the indirect port
// ------------------------------------------------------------
module anr_mmd_model (
	// clock
	input wire logic clock,
	// access
	input wire logic mmd_wr,
	input wire logic [4:0] mmd_dev,
	input wire logic [15:0] mmd_addr,
	input wire logic [15:0] mmd_wdata,
	output logic [15:0] mmd_rdata
);
	logic [15:0] mem [0:255];
	initial foreach (mem[i]) mem[i] = 16'h0000;
	assign mmd_rdata = mem[{mmd_dev[3:0], mmd_addr[3:0]}];
	always @(posedge clock) begin
		if (mmd_wr) begin
			mem[{mmd_dev[3:0], mmd_addr[3:0]}] <= mmd_wdata;
		end
	end
endmodule : anr_mmd_model

// file: verification/anr_regs_tb.sv
`timescale 1ns/1ps
module anr_regs_tb;
	logic clock = 1'b0, rstn = 1'b0, mgmt_rd = 1'b0, mgmt_wr = 1'b0, tx_toggle = 1'b0;
	logic np_able = 1'b0, an_able = 1'b0, pd_fault = 1'b0, page_rx = 1'b0, mmd_rd, mmd_wr;
	logic [4:0] mgmt_addr = 5'h00, mmd_dev;
	logic [15:0] mgmt_wdata = 16'h0000, base_in = 16'h0000, np_in = 16'h0000;
	logic [15:0] mgmt_rdata, local_np_out, mmd_addr, mmd_wdata, mmd_rdata;
	int mismatches = 0, n_tests = 0;
	always #4 clock = ~clock;
	anr_regs dut (.clock(clock), .rstn(rstn), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
		.mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.partner_base_in(base_in), .partner_np_in(np_in), .partner_np_able(np_able),
		.partner_an_able(an_able), .par_det_fault(pd_fault), .page_rx(page_rx),
		.tx_toggle(tx_toggle), .local_np_out(local_np_out), .mmd_rd(mmd_rd), .mmd_wr(mmd_wr),
		.mmd_dev(mmd_dev), .mmd_addr(mmd_addr), .mmd_wdata(mmd_wdata), .mmd_rdata(mmd_rdata));
	anr_mmd_model mdl (.clock(clock), .mmd_wr(mmd_wr), .mmd_dev(mmd_dev), .mmd_addr(mmd_addr),
		.mmd_wdata(mmd_wdata), .mmd_rdata(mmd_rdata));
	// ------------------------------------------------------------
	// access and compare
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		mgmt_addr = a;
		mgmt_rd = 1'b1;
		@(negedge clock);
		mgmt_rd = 1'b0;
		chk(mgmt_rdata, e);
		repeat (2) @(negedge clock);
	endtask : rd
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		mgmt_addr = a;
		mgmt_wdata = d;
		mgmt_wr = 1'b1;
		@(negedge clock);
		mgmt_wr = 1'b0;
		repeat (2) @(negedge clock);
	endtask : wr
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd(5'h05, 16'h0001);
		rd(5'h06, 16'h0004);
		rd(5'h07, 16'h2001);
		rd(5'h08, 16'h0000);
		rd(5'h0d, 16'h0000);
		rd(5'h0e, 16'h0000);
		rd(5'h1f, 16'h0000);
		chk(local_np_out, 16'h2001);
		$display("test reset done");
	endtask : t_reset
	task automatic t_latch;
		pd_fault = 1'b1;
		@(negedge clock);
		pd_fault = 1'b0;
		rd(5'h06, 16'h0014);
		rd(5'h06, 16'h0004);
		page_rx = 1'b1;
		@(negedge clock);
		page_rx = 1'b0;
		rd(5'h06, 16'h0006);
		rd(5'h06, 16'h0004);
		$display("test latch done");
	endtask : t_latch
	task automatic t_local_np;
		wr(5'h07, 16'hffff);
		rd(5'h07, 16'hb7ff);
		chk(local_np_out, 16'hb7ff);
		tx_toggle = 1'b1;
		@(negedge clock);
		rd(5'h07, 16'hbfff);
		wr(5'h07, 16'h0000);
		rd(5'h07, 16'h0800);
		tx_toggle = 1'b0;
		$display("test next page done");
	endtask : t_local_np
	task automatic t_mmd;
		wr(5'h0d, 16'h0003);
		wr(5'h0e, 16'h0002);
		rd(5'h0e, 16'h0002);
		rd(5'h0d, 16'h0003);
		wr(5'h0d, 16'h4003);
		wr(5'h0e, 16'haaaa);
		rd(5'h0e, 16'haaaa);
		rd(5'h0e, 16'haaaa);
		wr(5'h0d, 16'h8003);
		wr(5'h0e, 16'hbbbb);
		wr(5'h0e, 16'hcccc);
		wr(5'h0d, 16'h0003);
		rd(5'h0e, 16'h0004);
		wr(5'h0e, 16'h0002);
		wr(5'h0d, 16'h8003);
		rd(5'h0e, 16'hbbbb);
		rd(5'h0e, 16'hcccc);
		wr(5'h0d, 16'h0003);
		wr(5'h0e, 16'h0002);
		wr(5'h0d, 16'hc003);
		rd(5'h0e, 16'hbbbb);
		rd(5'h0e, 16'hbbbb);
		wr(5'h0e, 16'hdddd);
		rd(5'h0e, 16'hcccc);
		wr(5'h0d, 16'h0005);
		rd(5'h0e, 16'h0000);
		$display("test indirect done");
	endtask : t_mmd
	task automatic t_partner;
		base_in = 16'hffff;
		np_in = 16'h5a5a;
		np_able = 1'b1;
		an_able = 1'b1;
		wr(5'h05, 16'h0000);
		rd(5'h05, 16'hffe1);
		rd(5'h06, 16'h000d);
		wr(5'h08, 16'h0000);
		rd(5'h08, 16'h5a5a);
		np_in = 16'ha5a5;
		@(negedge clock);
		rd(5'h08, 16'ha5a5);
		$display("test partner done");
	endtask : t_partner
	initial begin
		repeat (10) @(negedge clock);
		rstn = 1'b1;
		t_reset();
		t_latch();
		t_local_np();
		t_mmd();
		t_partner();
		finish_test();
	end
	initial begin
		repeat (100000) @(posedge clock);
		mismatches++;
		$display("[FAIL] %0t run limit reached", $time);
		finish_test();
	end
endmodule : anr_regs_tb
bind anr_regs anr_regs_assertions chk (.clock(clock), .rstn(rstn), .mgmt_rd(mgmt_rd),
	.mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
	.partner_base_in(partner_base_in), .partner_np_in(partner_np_in),
	.partner_np_able(partner_np_able), .partner_an_able(partner_an_able),
	.par_det_fault(par_det_fault), .page_rx(page_rx), .tx_toggle(tx_toggle),
	.mmd_rd(mmd_rd), .mmd_wr(mmd_wr), .mmd_wdata(mmd_wdata));
